// ==== src/diag_ctl_pkg.sv ====
`default_nettype none
package diag_ctl_pkg;

	// ==========================================================
	// register offsets
	localparam logic [7:0] OFS_TEST_CTL = 8'hb3;
	localparam logic [7:0] OFS_RSVD_B4 = 8'hb4;
	localparam logic [7:0] OFS_RSVD_B5 = 8'hb5;
	localparam logic [7:0] OFS_RSVD_B6 = 8'hb6;
	localparam logic [7:0] OFS_RSVD_B7 = 8'hb7;
	localparam logic [7:0] OFS_STRAP_STS = 8'hb8;
	localparam logic [7:0] OFS_LINK_ERR = 8'hb9;
	localparam logic [7:0] OFS_ENC_CTL = 8'hba;
	localparam logic [7:0] OFS_RSVD_BB = 8'hbb;

	// ==========================================================
	// fixed read values of reserved registers
	localparam logic [7:0] RSVD_B4_VAL = 8'h25;
	localparam logic [7:0] RSVD_B5_VAL = 8'h00;
	localparam logic [7:0] RSVD_B6_VAL = 8'h18;
	localparam logic [7:0] RSVD_B7_VAL = 8'h00;
	localparam logic [7:0] RSVD_BB_VAL = 8'h74;
	localparam logic [7:0] UNMAPPED_VAL = 8'h00;

	// ==========================================================
	// self test control fields
	localparam int TEST_MODE_LSB = 6;
	localparam int TEST_CFGSEL_BIT = 3;
	localparam int TEST_CLKSRC_LSB = 1;
	localparam int TEST_EN_BIT = 0;
	localparam logic [7:0] TEST_CTL_RST = 8'h08;
	localparam logic [7:0] TEST_CTL_WMASK = 8'hcf;

	// ==========================================================
	// link error monitor fields
	localparam int LINK_WAIT_BIT = 5;
	localparam int LINK_CNTEN_BIT = 4;
	localparam int LINK_THRESH_LSB = 0;
	localparam logic [7:0] LINK_ERR_RST = 8'h33;
	localparam logic [7:0] LINK_ERR_WMASK = 8'h3f;

	// ==========================================================
	// encoder crc control fields
	localparam int ENC_CRC_DIS_BIT = 7;
	localparam logic [7:0] ENC_CTL_RST = 8'h83;
	localparam logic [7:0] ENC_CTL_WMASK = 8'h80;

	// ==========================================================
	// remote serializer clock-source target
	localparam logic [7:0] REMOTE_CLKSRC_OFS = 8'h14;

	// ==========================================================
	// strap decode time
	localparam int CLK_PERIOD_PS = 4000;
	localparam int STRAP_DECODE_NS = 100;
	localparam int STRAP_DECODE_CYC = (STRAP_DECODE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		PAT_NONE = 2'b00,
		PAT_ALTERNATE = 2'b01,
		PAT_DATA_A = 2'b10,
		PAT_DATA_B = 2'b11
	} pattern_mode_t;

endpackage : diag_ctl_pkg
`default_nettype wire

// ==== src/deser_shared_diag_control.sv ====
// Operation
// - pattern mode 00 quiet, 01 alternates, upper bit set follows test data.
// - test settings act only while the configuration-select bit is clear; resets to one.
// - clock-source field is copied to serializer offset 0x14 by hardware.
// - that copy happens once the test enable bit is set; clearing stops test.
// - index done bit 7 sets after index strap value is latched.
// - bits 6:4 show the 3-bit value decoded from the index strap.
// - configuration done bit 3 sets after configuration strap value is latched.
// - bits 2:0 show the 3-bit value decoded from the configuration strap.
// - wait-ignore bit set masks errors during equalizer filter wait period.
// - link errors are counted only while count enable is one; resets one.
// - with counting on, lock drops when the counter reaches the threshold (reset 3).
// - with counting off, lock drops on the first link error.
// - counter runs on SYS_CLK and counts only while PIXEL_EN is set, watching clock bits, parity and alignment bit.
// - encoder crc checking on when bit 7 is zero; bit resets to one.
`timescale 1ns/1ps
`default_nettype none

module deser_shared_diag_control (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic [2:0] INDEX_STRAP,
	input wire logic [2:0] CONFIG_STRAP,
	input wire logic TEST_DATA,
	output logic TEST_PATTERN,
	output logic REMOTE_WR,
	output logic [7:0] REMOTE_ADDR,
	output logic [1:0] REMOTE_CLKSRC,
	input wire logic PIXEL_EN,
	input wire logic ERR_CLK_A,
	input wire logic ERR_CLK_B,
	input wire logic ERR_PARITY,
	input wire logic ERR_ALIGN,
	input wire logic EQ_WAIT,
	input wire logic LOCK_ACQUIRE,
	output logic LINK_LOCK,
	output logic CRC_CHECK_EN
);

	// ==========================================================
	// storage
	logic [7:0] test_ctl_q;
	logic [7:0] link_ctl_q;
	logic enc_crc_dis_q;
	logic [7:0] rdata_q;
	logic pattern_q;
	logic active_prev_q;
	logic remote_wr_q;
	logic [7:0] remote_addr_q;
	logic [1:0] remote_clksrc_q;
	logic [7:0] decode_cnt_q;
	logic index_done_q;
	logic [2:0] index_val_q;
	logic config_done_q;
	logic [2:0] config_val_q;
	logic lock_q;
	logic [3:0] err_cnt_q;
	logic crc_en_q;

	logic test_active;
	logic [1:0] pattern_mode;
	logic [1:0] clksrc;
	logic wait_ignore;
	logic count_en;
	logic [3:0] thresh;
	logic any_err;
	logic err_hit;
	logic [4:0] cnt_next;
	logic drop;
	logic [7:0] rd_mux;

	// ==========================================================
	// field decode
	assign pattern_mode = test_ctl_q[diag_ctl_pkg::TEST_MODE_LSB +: 2];
	assign clksrc = test_ctl_q[diag_ctl_pkg::TEST_CLKSRC_LSB +: 2];
	assign test_active = test_ctl_q[diag_ctl_pkg::TEST_EN_BIT]
		& ~test_ctl_q[diag_ctl_pkg::TEST_CFGSEL_BIT];
	assign wait_ignore = link_ctl_q[diag_ctl_pkg::LINK_WAIT_BIT];
	assign count_en = link_ctl_q[diag_ctl_pkg::LINK_CNTEN_BIT];
	assign thresh = link_ctl_q[diag_ctl_pkg::LINK_THRESH_LSB +: 4];

	// ==========================================================
	// register writes
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			test_ctl_q <= diag_ctl_pkg::TEST_CTL_RST;
			link_ctl_q <= diag_ctl_pkg::LINK_ERR_RST;
			enc_crc_dis_q <= diag_ctl_pkg::ENC_CTL_RST[diag_ctl_pkg::ENC_CRC_DIS_BIT];
		end else if (REG_WR) begin
			if (REG_ADDR == diag_ctl_pkg::OFS_TEST_CTL) begin
				test_ctl_q <= REG_WDATA & diag_ctl_pkg::TEST_CTL_WMASK;
			end
			if (REG_ADDR == diag_ctl_pkg::OFS_LINK_ERR) begin
				link_ctl_q <= REG_WDATA & diag_ctl_pkg::LINK_ERR_WMASK;
			end
			if (REG_ADDR == diag_ctl_pkg::OFS_ENC_CTL) begin
				enc_crc_dis_q <= REG_WDATA[diag_ctl_pkg::ENC_CRC_DIS_BIT];
			end
		end
	end

	// ==========================================================
	// register reads
	always_comb begin
		unique case (REG_ADDR)
			diag_ctl_pkg::OFS_TEST_CTL: rd_mux = test_ctl_q;
			diag_ctl_pkg::OFS_RSVD_B4: rd_mux = diag_ctl_pkg::RSVD_B4_VAL;
			diag_ctl_pkg::OFS_RSVD_B5: rd_mux = diag_ctl_pkg::RSVD_B5_VAL;
			diag_ctl_pkg::OFS_RSVD_B6: rd_mux = diag_ctl_pkg::RSVD_B6_VAL;
			diag_ctl_pkg::OFS_RSVD_B7: rd_mux = diag_ctl_pkg::RSVD_B7_VAL;
			diag_ctl_pkg::OFS_STRAP_STS: begin
				rd_mux = {index_done_q, index_val_q, config_done_q, config_val_q};
			end
			diag_ctl_pkg::OFS_LINK_ERR: rd_mux = link_ctl_q;
			diag_ctl_pkg::OFS_ENC_CTL: begin
				rd_mux = {enc_crc_dis_q, diag_ctl_pkg::ENC_CTL_RST[6:0]};
			end
			diag_ctl_pkg::OFS_RSVD_BB: rd_mux = diag_ctl_pkg::RSVD_BB_VAL;
			default: rd_mux = diag_ctl_pkg::UNMAPPED_VAL;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			rdata_q <= 8'h00;
		end else if (REG_RD) begin
			rdata_q <= rd_mux;
		end
	end

	// ==========================================================
	// self test pattern
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			pattern_q <= 1'b0;
		end else if (!test_active) begin
			pattern_q <= 1'b0;
		end else begin
			unique case (pattern_mode)
				diag_ctl_pkg::PAT_NONE: pattern_q <= 1'b0;
				diag_ctl_pkg::PAT_ALTERNATE: pattern_q <= ~pattern_q;
				diag_ctl_pkg::PAT_DATA_A, diag_ctl_pkg::PAT_DATA_B: pattern_q <= TEST_DATA;
			endcase
		end
	end

	// ==========================================================
	// clock-source push to remote serializer
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			active_prev_q <= 1'b0;
			remote_wr_q <= 1'b0;
			remote_addr_q <= 8'h00;
			remote_clksrc_q <= 2'b00;
		end else begin
			active_prev_q <= test_active;
			remote_wr_q <= test_active & ~active_prev_q;
			remote_addr_q <= diag_ctl_pkg::REMOTE_CLKSRC_OFS;
			if (test_active & ~active_prev_q) begin
				remote_clksrc_q <= clksrc;
			end
		end
	end

	// ==========================================================
	// strap decode after reset release
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			decode_cnt_q <= 8'h00;
			index_done_q <= 1'b0;
			index_val_q <= 3'h0;
			config_done_q <= 1'b0;
			config_val_q <= 3'h0;
		end else if (!index_done_q) begin
			if (decode_cnt_q == 8'(diag_ctl_pkg::STRAP_DECODE_CYC - 1)) begin
				index_val_q <= INDEX_STRAP;
				config_val_q <= CONFIG_STRAP;
				index_done_q <= 1'b1;
				config_done_q <= 1'b1;
			end else begin
				decode_cnt_q <= decode_cnt_q + 8'h01;
			end
		end
	end

	// ==========================================================
	// link error monitor
	assign any_err = ERR_CLK_A | ERR_CLK_B | ERR_PARITY | ERR_ALIGN;
	assign err_hit = PIXEL_EN & any_err & lock_q & ~(wait_ignore & EQ_WAIT);
	assign cnt_next = {1'b0, err_cnt_q} + 5'h01;
	assign drop = err_hit & (~count_en | (cnt_next >= {1'b0, thresh}));

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			lock_q <= 1'b0;
		end else if (drop) begin
			lock_q <= 1'b0;
		end else if (LOCK_ACQUIRE) begin
			lock_q <= 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			err_cnt_q <= 4'h0;
		end else if (drop | (LOCK_ACQUIRE & ~lock_q)) begin
			err_cnt_q <= 4'h0;
		end else if (err_hit & count_en) begin
			err_cnt_q <= cnt_next[3:0];
		end
	end

	// ==========================================================
	// encoder crc enable
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			crc_en_q <= 1'b0;
		end else begin
			crc_en_q <= ~enc_crc_dis_q;
		end
	end

	// ==========================================================
	// outputs
	assign REG_RDATA = rdata_q;
	assign TEST_PATTERN = pattern_q;
	assign REMOTE_WR = remote_wr_q;
	assign REMOTE_ADDR = remote_addr_q;
	assign REMOTE_CLKSRC = remote_clksrc_q;
	assign LINK_LOCK = lock_q;
	assign CRC_CHECK_EN = crc_en_q;

	// ==========================================================
	// assertions
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	sequence s_test_rise;
		!test_active ##1 test_active;
	endsequence

	sequence s_remote_push;
		REMOTE_WR && REMOTE_ADDR == diag_ctl_pkg::REMOTE_CLKSRC_OFS;
	endsequence

	a_pattern_quiet: assert property (
		(!test_active || pattern_mode == diag_ctl_pkg::PAT_NONE) |=> !TEST_PATTERN)
		else $error("pattern not quiet");

	a_pattern_alternate: assert property (
		(test_active && pattern_mode == diag_ctl_pkg::PAT_ALTERNATE)
		|=> TEST_PATTERN != $past(TEST_PATTERN))
		else $error("pattern did not alternate");

	a_pattern_data: assert property (
		(test_active && pattern_mode[1]) |=> TEST_PATTERN == $past(TEST_DATA))
		else $error("pattern not following test data");

	a_cfgsel_block: assert property (
		test_ctl_q[diag_ctl_pkg::TEST_CFGSEL_BIT] |=> !REMOTE_WR)
		else $error("push while configuration select set");

	a_clksrc_push: assert property (
		s_test_rise |=> s_remote_push ##0 REMOTE_CLKSRC == $past(clksrc))
		else $error("clock source push missing or wrong");

	a_push_single: assert property (
		REMOTE_WR |=> !REMOTE_WR [*2])
		else $error("push repeated");

	a_index_latch: assert property (
		$rose(index_done_q) |-> index_val_q == $past(INDEX_STRAP))
		else $error("index strap not latched");

	a_config_latch: assert property (
		$rose(config_done_q) |-> config_val_q == $past(CONFIG_STRAP) && index_done_q)
		else $error("configuration strap not latched");

	a_wait_ignore: assert property (
		(lock_q && wait_ignore && EQ_WAIT) |=> LINK_LOCK)
		else $error("lock lost during ignored wait");

	a_count_off: assert property (
		(!count_en && !LOCK_ACQUIRE) |=> err_cnt_q == $past(err_cnt_q) || err_cnt_q == 4'h0)
		else $error("counter moved while disabled");

	a_thresh_drop: assert property (
		(err_hit && count_en && cnt_next >= {1'b0, thresh}) |=> !LINK_LOCK ##0 err_cnt_q == 4'h0)
		else $error("no drop at threshold");

	a_first_drop: assert property (
		(err_hit && !count_en) |=> !LINK_LOCK)
		else $error("no drop on first error");

	a_acquire_clear: assert property (
		(LOCK_ACQUIRE && !lock_q) |=> LINK_LOCK && err_cnt_q == 4'h0)
		else $error("counter not cleared on lock");

	a_crc_follow: assert property (
		##1 1'b1 |-> CRC_CHECK_EN == !$past(enc_crc_dis_q))
		else $error("crc enable wrong");

	a_rsvd_read: assert property (
		(REG_RD && REG_ADDR == diag_ctl_pkg::OFS_RSVD_B4) |=> REG_RDATA == diag_ctl_pkg::RSVD_B4_VAL)
		else $error("reserved read value wrong");

	a_remote_addr: assert property (
		REMOTE_WR |-> REMOTE_ADDR == diag_ctl_pkg::REMOTE_CLKSRC_OFS)
		else $error("push to wrong serializer offset");

	a_index_read: assert property (
		(REG_RD && REG_ADDR == diag_ctl_pkg::OFS_STRAP_STS)
		|=> REG_RDATA[7:4] == {$past(index_done_q), $past(index_val_q)})
		else $error("index status read wrong");

	a_config_read: assert property (
		(REG_RD && REG_ADDR == diag_ctl_pkg::OFS_STRAP_STS)
		|=> REG_RDATA[3:0] == {$past(config_done_q), $past(config_val_q)})
		else $error("configuration status read wrong");

	a_count_step: assert property (
		(err_hit && count_en && !drop) |=> err_cnt_q == $past(err_cnt_q) + 4'h1)
		else $error("error not counted");

	a_drop_clear: assert property (
		$fell(LINK_LOCK) |-> err_cnt_q == 4'h0)
		else $error("counter not cleared on drop");

	a_crc_write: assert property (
		(REG_WR && REG_ADDR == diag_ctl_pkg::OFS_ENC_CTL)
		|=> ##1 CRC_CHECK_EN == !$past(REG_WDATA[diag_ctl_pkg::ENC_CRC_DIS_BIT], 2))
		else $error("crc enable does not follow write");

	a_mask_write: assert property (
		(REG_WR && REG_ADDR == diag_ctl_pkg::OFS_TEST_CTL) |=> test_ctl_q[5:4] == 2'b00)
		else $error("reserved test bits written");

endmodule : deser_shared_diag_control

`default_nettype wire

// ==== testbench/remote_serializer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// far-end serializer: keeps the pushed clock source
module remote_serializer_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [1:0] clksrc,
	output logic [1:0] clk_source_q,
	output var int writes,
	output var int stray
);
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_source_q <= 2'h0;
			writes <= 0;
			stray <= 0;
		end else if (wr && addr == 8'h14) begin
			clk_source_q <= clksrc;
			writes <= writes + 1;
		end else if (wr) begin
			stray <= stray + 1;
		end
	end
endmodule : remote_serializer_model
`default_nettype wire

// ==== testbench/tb_deser_shared_diag_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_deser_shared_diag_control;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic tdata = 1'b0;
	logic [2:0] index_strap = 3'h5;
	logic [2:0] config_strap = 3'h2;
	logic pat;
	logic rwr;
	logic [7:0] raddr;
	logic [1:0] rsrc;
	logic pix = 1'b0;
	logic [3:0] err = 4'h0;
	logic eqw = 1'b0;
	logic acq = 1'b0;
	logic lock;
	logic crc;
	logic [1:0] msrc;
	int mwr;
	int mstray;
	int fail_count = 0;
	int tests_run = 0;
	logic [7:0] ra [5] = '{8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hbb};
	logic [7:0] rv [5] = '{8'h25, 8'h00, 8'h18, 8'h00, 8'h74};

	always #2 clk = ~clk;

	deser_shared_diag_control i_deser_shared_diag_control (.SYS_CLK(clk), .SYS_RST(rst),
		.REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.INDEX_STRAP(index_strap), .CONFIG_STRAP(config_strap),
		.TEST_DATA(tdata), .TEST_PATTERN(pat),
		.REMOTE_WR(rwr), .REMOTE_ADDR(raddr), .REMOTE_CLKSRC(rsrc), .PIXEL_EN(pix),
		.ERR_CLK_A(err[0]), .ERR_CLK_B(err[1]), .ERR_PARITY(err[2]), .ERR_ALIGN(err[3]),
		.EQ_WAIT(eqw), .LOCK_ACQUIRE(acq), .LINK_LOCK(lock), .CRC_CHECK_EN(crc));
	remote_serializer_model i_remote_serializer_model (.clk(clk), .rst(rst), .wr(rwr),
		.addr(raddr), .clksrc(rsrc), .clk_source_q(msrc), .writes(mwr), .stray(mstray));

	// ====
	// bus and link helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		wr = 1'b1;
		addr = a;
		wdata = d;
		cyc(1);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		cyc(1);
		rd = 1'b1;
		addr = a;
		cyc(1);
		rd = 1'b0;
		`CHK("read data", e, rdata)
	endtask : rd_chk
	task automatic acquire;
		cyc(1);
		acq = 1'b1;
		cyc(1);
		acq = 1'b0;
		cyc(1);
	endtask : acquire
	task automatic errs(input logic [3:0] m, input int n, input logic pe);
		repeat (n) begin
			cyc(1);
			err = m;
			pix = pe;
		end
		cyc(1);
		err = 4'h0;
		pix = 1'b0;
	endtask : errs

	// ====
	// scenarios
	task automatic t_regs;
		rd_chk(8'hb8, 8'h00);
		rd_chk(8'hb3, 8'h08);
		rd_chk(8'hb9, 8'h33);
		rd_chk(8'hba, 8'h83);
		`CHK("crc check at reset", 1'b0, crc)
		for (int i = 0; i < 5; i++) begin
			wr_reg(ra[i], 8'hff);
			rd_chk(ra[i], rv[i]);
		end
		rd_chk(8'hc0, 8'h00);
		cyc(30);
		wr_reg(8'hb8, 8'h00);
		rd_chk(8'hb8, 8'hda);
	endtask : t_regs
	task automatic t_remote;
		wr_reg(8'hb3, 8'h0d);
		cyc(4);
		`CHK("push while reserved config", 0, mwr)
		wr_reg(8'hb3, 8'h05);
		cyc(10);
		`CHK("push count", 1, mwr)
		`CHK("serializer clock source", 2'h2, msrc)
		wr_reg(8'hb3, 8'h04);
		wr_reg(8'hb3, 8'h03);
		cyc(4);
		`CHK("second push", 2, mwr)
		`CHK("second clock source", 2'h1, msrc)
		`CHK("stray writes", 0, mstray)
		wr_reg(8'hb3, 8'hff);
		rd_chk(8'hb3, 8'hcf);
	endtask : t_remote
	task automatic t_pattern;
		logic p;
		wr_reg(8'hb3, 8'h00);
		wr_reg(8'hb3, 8'h41);
		cyc(2);
		p = pat;
		cyc(1);
		`CHK("alternating pattern", 1'b1, p ^ pat)
		wr_reg(8'hb3, 8'h01);
		repeat (3) begin
			tdata = ~tdata;
			cyc(1);
			`CHK("quiet pattern", 1'b0, pat)
		end
		for (int m = 2; m < 4; m++) begin
			wr_reg(8'hb3, 8'h00);
			wr_reg(8'hb3, {m[1:0], 6'h01});
			for (int b = 0; b < 3; b++) begin
				tdata = b[0];
				cyc(1);
				`CHK("data pattern", b[0], pat)
			end
		end
		wr_reg(8'hb3, 8'h80);
		tdata = 1'b1;
		cyc(2);
		`CHK("pattern when disabled", 1'b0, pat)
	endtask : t_pattern
	task automatic t_link;
		wr_reg(8'hb9, 8'hff);
		rd_chk(8'hb9, 8'h3f);
		wr_reg(8'hb9, 8'h13);
		acquire();
		`CHK("lock acquired", 1'b1, lock)
		errs(4'h4, 2, 1'b0);
		`CHK("errors without pixel enable", 1'b1, lock)
		errs(4'h4, 2, 1'b1);
		`CHK("below threshold", 1'b1, lock)
		errs(4'h4, 1, 1'b1);
		`CHK("threshold reached", 1'b0, lock)
		acquire();
		errs(4'h1, 2, 1'b1);
		`CHK("count restarts", 1'b1, lock)
		wr_reg(8'hb9, 8'h03);
		for (int i = 0; i < 4; i++) begin
			acquire();
			errs(4'h1 << i, 1, 1'b1);
			`CHK("first error drops", 1'b0, lock)
		end
		eqw = 1'b1;
		acquire();
		errs(4'h2, 1, 1'b1);
		`CHK("wait errors counted", 1'b0, lock)
		wr_reg(8'hb9, 8'h23);
		acquire();
		errs(4'h8, 1, 1'b1);
		`CHK("wait errors ignored", 1'b1, lock)
		eqw = 1'b0;
		errs(4'h8, 1, 1'b1);
		`CHK("error after wait", 1'b0, lock)
	endtask : t_link
	task automatic t_crc;
		wr_reg(8'hba, 8'h00);
		cyc(1);
		`CHK("crc check on", 1'b1, crc)
		rd_chk(8'hba, 8'h03);
		wr_reg(8'hba, 8'hff);
		cyc(1);
		`CHK("crc check off", 1'b0, crc)
		rd_chk(8'hba, 8'h83);
	endtask : t_crc
	task automatic t_reset;
		acquire();
		wr_reg(8'hba, 8'h00);
		index_strap = 3'h3;
		config_strap = 3'h6;
		cyc(1);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		`CHK("lock after reset", 1'b0, lock)
		`CHK("crc check after reset", 1'b0, crc)
		rd_chk(8'hb8, 8'h00);
		rd_chk(8'hb9, 8'h33);
		cyc(30);
		rd_chk(8'hb8, 8'hbe);
	endtask : t_reset

	// ====
	// run control
	task automatic test_done;
		$display("checks run %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	initial begin
		cyc(12);
		rst = 1'b0;
		t_regs();
		t_remote();
		t_pattern();
		t_link();
		t_crc();
		t_reset();
		test_done();
	end
	initial begin
		#20000;
		fail_count++;
		test_done();
	end
endmodule : tb_deser_shared_diag_control
`default_nettype wire
